/* pca_pkg.sv */
package pca_pkg;

  localparam int num_modules = 5;
  localparam int wd_module = 4;

  // Register byte addresses
  localparam logic [7:0] addr_control = 8'h00;
  localparam logic [7:0] addr_mode = 8'h04;
  localparam logic [7:0] addr_count_low = 8'h08;
  localparam logic [7:0] addr_count_high = 8'h0c;
  localparam logic [7:0] addr_irq_status = 8'h10;
  localparam logic [7:0] addr_module_base = 8'h20;
  localparam logic [7:0] addr_module_stride = 8'h10;
  localparam logic [7:0] off_module_mode = 8'h00;
  localparam logic [7:0] off_compare_low = 8'h04;
  localparam logic [7:0] off_compare_high = 8'h08;
  localparam logic [7:0] off_pin_state = 8'h0c;

  // Counter control register fields
  localparam int ctl_run_bit = 6;
  localparam int ctl_flags_lsb = 0;

  // Counter mode register fields
  localparam int wd_reset_enable_bit = 6;
  localparam int prescale_lsb = 0;
  localparam int prescale_width = 4;

  // Module mode register fields
  localparam int mm_compare_enable = 6;
  localparam int mm_match_event_enable = 3;
  localparam int mm_toggle_enable = 2;
  localparam int mm_pwm_enable = 1;
  localparam int mm_module_irq_enable = 0;

  // Reset values
  localparam logic [7:0] control_reset = 8'h00;
  localparam logic [7:0] mode_reset = 8'h00;
  localparam logic [7:0] module_mode_reset = 8'h00;
  localparam logic [7:0] compare_reset = 8'h00;
  localparam logic [15:0] counter_reset = 16'h0000;

  // Internal reset pulse length in clock cycles
  localparam int wd_reset_cycles = 16;

  localparam logic [1:0] resp_okay = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;

  typedef struct packed {
    logic compare_enable;
    logic match_event_enable;
    logic toggle_enable;
    logic pwm_enable;
    logic module_irq_enable;
  } module_mode_t;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
  } compare_pair_t;

endpackage

/* pca_compare_unit.sv */
module pca_compare_unit (
  input wire logic aclk,
  input wire logic aresetn,
  input wire pca_pkg::module_mode_t mode,
  input wire pca_pkg::compare_pair_t compare,
  input wire logic compare_armed,
  input wire logic [15:0] count,
  input wire logic count_tick,
  output logic match_pulse,
  output logic pin_level,
  output logic pwm_reload
);

  logic next_match_pulse;
  logic next_pin_level;
  logic next_pwm_reload;
  logic compare_mode;
  logic hso_mode;
  logic pwm_mode;

  always_comb begin
    compare_mode = mode.compare_enable & mode.match_event_enable;
    hso_mode = compare_mode & mode.toggle_enable;
    pwm_mode = mode.compare_enable & mode.pwm_enable;
    next_match_pulse = 1'b0;
    next_pin_level = pin_level;
    next_pwm_reload = 1'b0;
    // Only sampled on a tick so one equality gives one event
    if (count_tick && compare_mode && compare_armed &&
        count == {compare.high, compare.low}) begin
      next_match_pulse = 1'b1;
      if (hso_mode) begin
        next_pin_level = ~pin_level;
      end
    end
    if (pwm_mode) begin
      next_pin_level = (count[7:0] >= compare.low);
      if (count_tick && count[7:0] == 8'hff) begin
        next_pwm_reload = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_pulse <= 1'b0;
      pin_level <= 1'b0;
      pwm_reload <= 1'b0;
    end else begin
      match_pulse <= next_match_pulse;
      pin_level <= next_pin_level;
      pwm_reload <= next_pwm_reload;
    end
  end

endmodule

/* pca_compare_array.sv */
// Overview of operation
// - Compare-enable plus match-enable: 16-bit counter equality with compare pair sets event.
// - Interrupt requested only when event flag and module interrupt enable both set.
// - Low-byte write suspends comparator; high-byte write re-arms it.
// - Toggle, match and compare enables together select high-speed output.
// - High-speed output inverts module pin on every 16-bit equality.
// - Unchanged compare pair toggles again after the counter wraps round.
// - PWM plus compare enable selects PWM; interrupt enable does not matter.
// - PWM output low while counter low byte below compare low, else high.
// - All five modules share one counter, hence one PWM period.
// - In PWM, high byte copies into low byte only at low-byte wrap.
// - Only module 4 can be the watchdog; otherwise it works normally.
// - Watchdog enabled and module 4 compare match triggers internal reset.
// - Watchdog reset stays internal and never drives the external reset pin.
// - Watchdog reset gated by reset-enable bit at mask 40h of mode register.
// - Hardware sets module event flag on match; only software clears it.
// - All-zero mode does nothing; interrupt enable ignored in PWM and watchdog.
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
module pca_compare_array (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [4:0] module_io_pin,
  output logic pca_irq,
  output logic wd_internal_reset
);

  localparam int n = pca_pkg::num_modules;

  ////////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] counter_control_reg, next_counter_control_reg;
  logic [7:0] counter_mode_reg, next_counter_mode_reg;
  logic [15:0] count, next_count;
  logic [7:0] module_mode_reg [n], next_module_mode_reg [n];
  pca_pkg::compare_pair_t compare [n], next_compare [n];
  logic [n-1:0] armed, next_armed;
  logic [3:0] div_count, next_div_count;
  logic count_tick, next_count_tick;
  logic [7:0] wd_pulse_count, next_wd_pulse_count;

  logic [n-1:0] match_pulse;
  logic [n-1:0] pin_level;
  logic [n-1:0] pwm_reload;
  pca_pkg::module_mode_t mode [n];

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake state
  logic [7:0] aw_addr, next_aw_addr;
  logic aw_held, next_aw_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic w_held, next_w_held;
  logic [1:0] next_bresp;
  logic next_bvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic next_rvalid;
  logic next_irq;
  logic next_wd_reset;
  logic do_write;

  function automatic logic is_mapped(input logic [7:0] a);
    logic hit;
    hit = (a == pca_pkg::addr_control) || (a == pca_pkg::addr_mode) ||
          (a == pca_pkg::addr_count_low) || (a == pca_pkg::addr_count_high) ||
          (a == pca_pkg::addr_irq_status);
    if (a >= pca_pkg::addr_module_base && a < 8'(pca_pkg::addr_module_base +
        8'(n) * pca_pkg::addr_module_stride) && a[1:0] == 2'b00) begin
      hit = 1'b1;
    end
    return hit;
  endfunction

  function automatic logic [2:0] module_index(input logic [7:0] a);
    logic [7:0] rel;
    rel = a - pca_pkg::addr_module_base;
    return rel[6:4];
  endfunction

  generate
    for (genvar i = 0; i < n; i++) begin : g_mod
      assign mode[i] = '{
        compare_enable: module_mode_reg[i][pca_pkg::mm_compare_enable],
        match_event_enable: module_mode_reg[i][pca_pkg::mm_match_event_enable],
        toggle_enable: module_mode_reg[i][pca_pkg::mm_toggle_enable],
        pwm_enable: module_mode_reg[i][pca_pkg::mm_pwm_enable],
        module_irq_enable: module_mode_reg[i][pca_pkg::mm_module_irq_enable]};
      // Same counter fans out to every module
      pca_compare_unit u_unit (
        .aclk(aclk),
        .aresetn(aresetn),
        .mode(mode[i]),
        .compare(compare[i]),
        .compare_armed(armed[i]),
        .count(count),
        .count_tick(count_tick),
        .match_pulse(match_pulse[i]),
        .pin_level(pin_level[i]),
        .pwm_reload(pwm_reload[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    logic [2:0] idx;
    logic [7:0] sub;
    logic [n-1:0] irq_terms;
    idx = 3'd0;
    sub = 8'h00;
    irq_terms = '0;
    next_aw_addr = aw_addr;
    next_aw_held = aw_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_w_held = w_held;
    next_bresp = s_axi_bresp;
    next_bvalid = s_axi_bvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_rvalid = s_axi_rvalid;
    next_counter_control_reg = counter_control_reg;
    next_counter_mode_reg = counter_mode_reg;
    next_count = count;
    next_module_mode_reg = module_mode_reg;
    next_compare = compare;
    next_armed = armed;
    next_div_count = div_count;
    next_count_tick = 1'b0;
    next_wd_pulse_count = wd_pulse_count;
    // Counter prescaler: one tick per (div + 1) clocks while running
    if (counter_control_reg[pca_pkg::ctl_run_bit]) begin
      if (div_count >= counter_mode_reg[pca_pkg::prescale_lsb +: pca_pkg::prescale_width]) begin
        next_div_count = 4'h0;
        next_count_tick = 1'b1;
      end else begin
        next_div_count = div_count + 4'h1;
      end
    end
    if (count_tick) begin
      next_count = count + 16'h0001;
    end

    // PWM reload from high byte at low-byte wrap
    for (int i = 0; i < n; i++) begin
      if (pwm_reload[i]) begin
        next_compare[i].low = compare[i].high;
      end
    end

    // Hardware sets flags; set wins over a same-cycle software clear
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_addr = s_axi_awaddr;
      next_aw_held = 1'b1;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
      next_w_held = 1'b1;
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = is_mapped(aw_addr) ? pca_pkg::resp_okay : pca_pkg::resp_slverr;
      if (w_strb[0]) begin
        idx = module_index(aw_addr);
        sub = aw_addr - pca_pkg::addr_module_base - 8'({idx, 4'h0});
        if (aw_addr == pca_pkg::addr_control) begin
          next_counter_control_reg = w_data[7:0];
        end else if (aw_addr == pca_pkg::addr_mode) begin
          next_counter_mode_reg = w_data[7:0];
        end else if (aw_addr == pca_pkg::addr_count_low) begin
          next_count[7:0] = w_data[7:0];
        end else if (aw_addr == pca_pkg::addr_count_high) begin
          next_count[15:8] = w_data[7:0];
        end else if (is_mapped(aw_addr) && aw_addr >= pca_pkg::addr_module_base) begin
          if (sub == pca_pkg::off_module_mode) begin
            next_module_mode_reg[idx] = w_data[7:0];
          end else if (sub == pca_pkg::off_compare_low) begin
            next_compare[idx].low = w_data[7:0];
            next_armed[idx] = 1'b0;
          end else if (sub == pca_pkg::off_compare_high) begin
            next_compare[idx].high = w_data[7:0];
            next_armed[idx] = 1'b1;
          end
        end
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    for (int i = 0; i < n; i++) begin
      if (match_pulse[i]) begin
        next_counter_control_reg[pca_pkg::ctl_flags_lsb + i] = 1'b1;
      end
    end

    if (s_axi_arvalid && s_axi_arready) begin
      idx = module_index(s_axi_araddr);
      sub = s_axi_araddr - pca_pkg::addr_module_base - 8'({idx, 4'h0});
      next_rvalid = 1'b1;
      next_rdata = 32'h0000_0000;
      next_rresp = is_mapped(s_axi_araddr) ? pca_pkg::resp_okay : pca_pkg::resp_slverr;
      if (s_axi_araddr == pca_pkg::addr_control) begin
        next_rdata[7:0] = counter_control_reg;
      end else if (s_axi_araddr == pca_pkg::addr_mode) begin
        next_rdata[7:0] = counter_mode_reg;
      end else if (s_axi_araddr == pca_pkg::addr_count_low) begin
        next_rdata[7:0] = count[7:0];
      end else if (s_axi_araddr == pca_pkg::addr_count_high) begin
        next_rdata[7:0] = count[15:8];
      end else if (s_axi_araddr == pca_pkg::addr_irq_status) begin
        next_rdata[0] = pca_irq;
      end else if (is_mapped(s_axi_araddr)) begin
        if (sub == pca_pkg::off_module_mode) begin
          next_rdata[7:0] = module_mode_reg[idx];
        end else if (sub == pca_pkg::off_compare_low) begin
          next_rdata[7:0] = compare[idx].low;
        end else if (sub == pca_pkg::off_compare_high) begin
          next_rdata[7:0] = compare[idx].high;
        end else begin
          next_rdata[0] = pin_level[idx];
        end
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    // PWM and watchdog use of module 4 mask the module interrupt
    for (int i = 0; i < n; i++) begin
      irq_terms[i] = counter_control_reg[pca_pkg::ctl_flags_lsb + i] &
                     mode[i].module_irq_enable & ~mode[i].pwm_enable;
    end
    if (counter_mode_reg[pca_pkg::wd_reset_enable_bit]) begin
      irq_terms[pca_pkg::wd_module] = 1'b0;
    end
    next_irq = |irq_terms;
    // Only module 4 feeds the watchdog, and only with its enable set
    next_wd_reset = 1'b0;
    if (wd_pulse_count != 8'h00) begin
      next_wd_pulse_count = wd_pulse_count - 8'h01;
      next_wd_reset = 1'b1;
    end
    if (match_pulse[pca_pkg::wd_module] &&
        counter_mode_reg[pca_pkg::wd_reset_enable_bit]) begin
      next_wd_pulse_count = 8'(pca_pkg::wd_reset_cycles - 1);
      next_wd_reset = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_control_reg <= pca_pkg::control_reset;
      counter_mode_reg <= pca_pkg::mode_reset;
      count <= pca_pkg::counter_reset;
      for (int i = 0; i < n; i++) begin
        module_mode_reg[i] <= pca_pkg::module_mode_reset;
        compare[i] <= '{low: pca_pkg::compare_reset, high: pca_pkg::compare_reset};
      end
      armed <= '1;
      div_count <= 4'h0;
      count_tick <= 1'b0;
      wd_pulse_count <= 8'h00;
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      w_held <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_bvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_arready <= 1'b0;
      module_io_pin <= 5'h00;
      pca_irq <= 1'b0;
      wd_internal_reset <= 1'b0;
    end else begin
      counter_control_reg <= next_counter_control_reg;
      counter_mode_reg <= next_counter_mode_reg;
      count <= next_count;
      module_mode_reg <= next_module_mode_reg;
      compare <= next_compare;
      armed <= next_armed;
      div_count <= next_div_count;
      count_tick <= next_count_tick;
      wd_pulse_count <= next_wd_pulse_count;
      aw_addr <= next_aw_addr;
      aw_held <= next_aw_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      w_held <= next_w_held;
      s_axi_bresp <= next_bresp;
      s_axi_bvalid <= next_bvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_awready <= !next_aw_held;
      s_axi_wready <= !next_w_held;
      s_axi_arready <= !next_rvalid;
      module_io_pin <= pin_level;
      pca_irq <= next_irq;
      // Kept on its own output; the external reset pin is never driven
      wd_internal_reset <= next_wd_reset;
    end
  end

endmodule

/* pca_compare_array_sva.sv */
module pca_compare_array_sva (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] module_io_pin,
  input wire logic pca_irq,
  input wire logic wd_internal_reset
);
  int wd_len;
  int next_wd_len;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Pulse length counted here: a repetition of 16 would be too costly to unroll
  always_comb begin
    next_wd_len = wd_internal_reset ? wd_len + 1 : 0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wd_len <= 0;
    end else begin
      wd_len <= next_wd_len;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid
      && !pca_irq && !wd_internal_reset && module_io_pin == 5'h00)
    else $error("outputs active after reset");
  a_wd_len_exact: assert property ($fell(wd_internal_reset)
      |-> wd_len == pca_pkg::wd_reset_cycles)
    else $error("internal reset pulse has wrong length");
  a_wd_len_max: assert property (wd_internal_reset |-> wd_len < pca_pkg::wd_reset_cycles)
    else $error("internal reset pulse too long");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == pca_pkg::resp_slverr
      |-> s_axi_rdata == 32'h00000000)
    else $error("error read carries data");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready while write held");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while answer pending");
  a_resp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read_err: cover property (s_axi_rvalid && s_axi_rresp == pca_pkg::resp_slverr);
  c_wd_pulse: cover property ($rose(wd_internal_reset));
  c_irq: cover property ($rose(pca_irq));
endmodule

bind pca_compare_array pca_compare_array_sva u_sva (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .module_io_pin(module_io_pin), .pca_irq(pca_irq), .wd_internal_reset(wd_internal_reset)
);

/* tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [1:0] r;
  } row_t;
  localparam logic [7:0] ctl = pca_pkg::addr_control;
  localparam logic [7:0] md = pca_pkg::addr_mode;
  localparam logic [7:0] cnt_lo = pca_pkg::addr_count_low;
  localparam logic [7:0] cnt_hi = pca_pkg::addr_count_high;
  localparam logic [7:0] om = pca_pkg::off_module_mode;
  localparam logic [7:0] ol = pca_pkg::off_compare_low;
  localparam logic [7:0] oh = pca_pkg::off_compare_high;
  localparam logic [7:0] op = pca_pkg::off_pin_state;
  localparam logic [1:0] ok = pca_pkg::resp_okay;
  localparam logic [1:0] er = pca_pkg::resp_slverr;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp, wrsp;
  logic [31:0] s_axi_rdata, rdat;
  logic [4:0] module_io_pin;
  logic pca_irq, wd_internal_reset;
  int failures = 0;
  int check_count = 0;
  int n;

  function automatic logic [7:0] ma(input int i, input logic [7:0] off);
    return 8'(pca_pkg::addr_module_base + pca_pkg::addr_module_stride * i + off);
  endfunction

  row_t rows [11] = '{'{ctl, 8'h00, ok}, '{md, 8'h00, ok}, '{cnt_lo, 8'h00, ok},
    '{cnt_hi, 8'h00, ok}, '{pca_pkg::addr_irq_status, 8'h00, ok}, '{ma(0, om), 8'h00, ok},
    '{ma(4, ol), 8'h00, ok}, '{ma(4, oh), 8'h00, ok}, '{ma(2, op), 8'h00, ok},
    '{8'h1c, 8'h00, er}, '{8'h70, 8'h00, er}};

  pca_compare_array uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .module_io_pin(module_io_pin), .pca_irq(pca_irq), .wd_internal_reset(wd_internal_reset)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #4 aclk = ~aclk;
  end

  task automatic summarize;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Address and data are offered together and each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ad;
    logic dd;
    ad = 1'b0;
    dd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge aclk);
      ad = ad | s_axi_awready;
      dd = dd | s_axi_wready;
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    wrsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic wait_bit(input logic [7:0] a, input int b);
    do rd(a, rdat, rrsp); while (rdat[b] !== 1'b1);
  endtask

  task automatic wait_pin(input int i, input logic v);
    while (module_io_pin[i] !== v) @(posedge aclk);
  endtask

  // Generous bound: the whole sequence needs only a few thousand cycles
  initial begin
    #(20000 * 8);
    failures++;
    $display("mismatch watchdog expected done seen hang");
    summarize();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    foreach (rows[i]) begin
      rd(rows[i].a, rdat, rrsp);
      chk("reset data", rdat, {24'h000000, rows[i].d});
      chk("reset resp", 32'(rrsp), 32'(rows[i].r));
    end
    wr(8'h70, 8'h55);
    chk("unmapped write resp", 32'(wrsp), 32'(er));
    wr(ma(0, om), 8'h49);
    wr(ma(0, ol), 8'h30);
    wr(ma(0, oh), 8'h00);
    wr(ma(1, om), 8'h48);
    wr(ma(1, ol), 8'h10);
    wr(ma(1, oh), 8'h00);
    wr(ctl, 8'h40);
    wait_bit(ctl, 1);
    chk("irq without enable", 32'(pca_irq), 32'h0);
    while (pca_irq !== 1'b1) @(posedge aclk);
    rd(ctl, rdat, rrsp);
    chk("flags after matches", rdat, 32'h00000043);
    wr(ctl, 8'h00);
    rd(pca_pkg::addr_irq_status, rdat, rrsp);
    chk("irq status after clear", rdat, 32'h00000000);
    chk("irq after clear", 32'(pca_irq), 32'h0);
    // Low byte alone must leave the comparator suspended
    wr(ma(0, om), 8'h00);
    wr(ma(1, om), 8'h00);
    wr(cnt_lo, 8'h00);
    wr(cnt_hi, 8'h00);
    wr(ma(2, om), 8'h48);
    wr(ma(2, ol), 8'h08);
    wr(ctl, 8'h40);
    do rd(cnt_lo, rdat, rrsp); while (rdat[7:0] < 8'h20);
    rd(ctl, rdat, rrsp);
    chk("flags with low byte only", rdat, 32'h00000040);
    wr(ctl, 8'h00);
    wr(cnt_lo, 8'h00);
    wr(cnt_hi, 8'h00);
    wr(ma(3, om), 8'h4c);
    wr(ma(3, ol), 8'h05);
    wr(ma(3, oh), 8'h00);
    wr(ctl, 8'h40);
    wait_pin(3, 1'b1);
    rd(ma(3, op), rdat, rrsp);
    chk("pin state after match", rdat, 32'h00000001);
    wr(ctl, 8'h00);
    wr(cnt_lo, 8'hf0);
    wr(cnt_hi, 8'hff);
    wr(ctl, 8'h40);
    wait_pin(3, 1'b0);
    rd(cnt_lo, rdat, rrsp);
    chk("toggle after wrap", 32'(rdat[7:0] >= 8'h05 && rdat[7:0] <= 8'h14), 32'h1);
    rd(cnt_hi, rdat, rrsp);
    chk("count high after wrap", rdat, 32'h00000000);
    wr(ctl, 8'h00);
    wr(ma(3, om), 8'h00);
    wr(cnt_lo, 8'h80);
    wr(cnt_hi, 8'h00);
    wr(ma(1, om), 8'h43);
    wr(ma(1, oh), 8'hc0);
    rd(ma(1, ol), rdat, rrsp);
    chk("pwm low before wrap", rdat, 32'h00000010);
    // Flag raised by software so the PWM interrupt mask is really exercised
    wr(ctl, 8'h42);
    wait_pin(1, 1'b0);
    wait_pin(1, 1'b1);
    rd(cnt_lo, rdat, rrsp);
    chk("pwm rise point", 32'(rdat[7:0] >= 8'hc0 && rdat[7:0] <= 8'hcc), 32'h1);
    chk("pwm irq", 32'(pca_irq), 32'h0);
    wr(ctl, 8'h00);
    rd(ma(1, ol), rdat, rrsp);
    chk("pwm low after wrap", rdat, 32'h000000c0);
    wr(ma(1, om), 8'h00);
    wr(cnt_lo, 8'h00);
    wr(cnt_hi, 8'h00);
    wr(ma(4, om), 8'h4c);
    wr(ma(4, ol), 8'h20);
    wr(ma(4, oh), 8'h00);
    wr(ctl, 8'h40);
    wait_bit(ctl, 4);
    chk("reset without enable", 32'(wd_internal_reset), 32'h0);
    chk("module 4 toggles", 32'(module_io_pin[4]), 32'h1);
    wr(ctl, 8'h00);
    wr(cnt_lo, 8'h00);
    wr(cnt_hi, 8'h00);
    wr(md, 8'h40);
    wr(ctl, 8'h40);
    while (wd_internal_reset !== 1'b1) @(posedge aclk);
    n = 0;
    while (wd_internal_reset === 1'b1) begin
      n++;
      @(posedge aclk);
    end
    chk("reset pulse length", 32'(n), 32'(pca_pkg::wd_reset_cycles));
    rd(md, rdat, rrsp);
    chk("mode kept after pulse", rdat, 32'h00000040);
    s_axi_wstrb <= 4'he;
    wr(md, 8'h0f);
    s_axi_wstrb <= 4'hf;
    rd(md, rdat, rrsp);
    chk("masked write ignored", rdat, 32'h00000040);
    // Service from the main sequence: compare moved ahead, watchdog still enabled
    wr(ctl, 8'h00);
    wr(cnt_lo, 8'h00);
    wr(cnt_hi, 8'h00);
    wr(ma(4, ol), 8'h00);
    wr(ma(4, oh), 8'h01);
    wr(ctl, 8'h40);
    do rd(cnt_lo, rdat, rrsp); while (rdat[7:0] < 8'h40);
    rd(ctl, rdat, rrsp);
    chk("flags with compare moved", rdat, 32'h00000040);
    chk("no reset with compare moved", 32'(wd_internal_reset), 32'h0);
    summarize();
  end
endmodule
